// *** rtl/frg_regs.svh ***
`ifndef FRG_REGS_SVH
`define FRG_REGS_SVH

// Register indices; byte address is four times the index
`define FRG_IDX_ENABLE     7'h00
`define FRG_IDX_TRIGGER    7'h61
`define FRG_IDX_A_STEP_HI  7'h62
`define FRG_IDX_A_STEP_LO  7'h63
`define FRG_IDX_A_LENGTH   7'h64
`define FRG_IDX_A_SEQ      7'h65
`define FRG_IDX_B_STEP_HI  7'h66
`define FRG_IDX_B_STEP_LO  7'h67
`define FRG_IDX_B_LENGTH   7'h68
`define FRG_IDX_B_SEQ      7'h69
`define FRG_IDX_CAL_SCALE  7'h6a
`define FRG_IDX_LOCK_CORE  7'h6e
`define FRG_IDX_CAP_BAND   7'h6f
`define FRG_IDX_AMP_CODE   7'h70

// Config slot numbers inside the word array
`define FRG_SLOT_ENABLE    4'h0
`define FRG_SLOT_TRIGGER   4'h1
`define FRG_SLOT_A_STEP_HI 4'h2
`define FRG_SLOT_A_STEP_LO 4'h3
`define FRG_SLOT_A_LENGTH  4'h4
`define FRG_SLOT_A_SEQ     4'h5
`define FRG_SLOT_B_STEP_HI 4'h6
`define FRG_SLOT_B_STEP_LO 4'h7
`define FRG_SLOT_B_LENGTH  4'h8
`define FRG_SLOT_B_SEQ     4'h9
`define FRG_SLOT_CAL_SCALE 4'ha
`define FRG_NUM_SLOTS      11

// Writable bit masks
`define FRG_MASK_ENABLE    16'h8000
`define FRG_MASK_TRIGGER   16'h07f8
`define FRG_MASK_A_STEP_HI 16'hfffd
`define FRG_MASK_B_STEP_HI 16'h3fff
`define FRG_MASK_A_SEQ     16'h0073
`define FRG_MASK_B_SEQ     16'hfff3
`define FRG_MASK_CAL_SCALE 16'h0017
`define FRG_MASK_FULL      16'hffff

// Field positions
`define FRG_BIT_ENABLE     15
`define FRG_BIT_A_DOUBLE   0
`define FRG_BIT_B_DOUBLE   6
`define FRG_BIT_B_CLEAR    5
`define FRG_BIT_NEXT       4
`define FRG_BIT_MANUAL     5
`define FRG_BIT_RECAL      4
`define FRG_BIT_LOCK       9
`define FRG_BIT_CORE       5

// Reset values
`define FRG_RST_CAL_SCALE  16'h0007
`define FRG_RST_CAP_BAND   8'hb7
`define FRG_RST_AMP_CODE   9'h0aa

// Trigger source codes
`define FRG_TRG_OFF        4'h0
`define FRG_TRG_CLK_RISE   4'h1
`define FRG_TRG_DIR_RISE   4'h2
`define FRG_TRG_ALWAYS     4'h4
`define FRG_TRG_CLK_FALL   4'h9
`define FRG_TRG_DIR_FALL   4'ha

// Advance source codes
`define FRG_ADV_LENGTH     2'h0
`define FRG_ADV_TRIG_A     2'h1
`define FRG_ADV_TRIG_B     2'h2

// Enable dividers: phase detector and state machine rates
`define FRG_PD_DIV         4'h4
`define FRG_SM_DIV         4'h8

`endif

// *** rtl/frg_pkg.sv ***
package frg_pkg;

    typedef enum logic [1:0] {
        FRG_IDLE,
        FRG_SEG_A,
        FRG_SEG_B,
        FRG_CAL
    } frg_state_t;

    typedef struct packed {
        logic [10:0][15:0] cfg;
        logic [1:0]        lock;
        logic [2:0]        core;
        logic [7:0]        cap;
        logic [8:0]        amp;
        frg_state_t        state;
        logic              next_b;
        logic [15:0]       len_cnt;
        logic              half;
        logic [16:0]       cal_cnt;
        logic [31:0]       accum;
        logic              cal_req;
        logic [3:0]        pd_cnt;
        logic [3:0]        sm_cnt;
        logic              clk_q;
        logic              dir_q;
        logic              ack;
        logic [31:0]       rdata;
        logic              err;
        logic              seg_b;
        logic              cal_on;
    } frg_st_t;

endpackage : frg_pkg

// *** rtl/frg_ramp.sv ***
// Function
// R1: first segment step is 30-bit signed, added every phase detector cycle.
// R2: second segment step is 30-bit signed, added every phase detector cycle.
// R3: double-length bit makes a segment advance every second phase detector cycle.
// R4: first segment length is a 16-bit phase detector cycle count.
// R5: second segment length is a 16-bit phase detector cycle count.
// R6: second segment clear bit zeroes the accumulator, automatic mode only.
// R7: after first segment, go to first (bit 0) or second (bit 1).
// R8: first segment leaves on length expiry, trigger A or trigger B.
// R9: after second segment, go to first (bit 0) or repeat second (bit 1).
// R10: second segment leaves on length expiry, trigger A or trigger B.
// R11: automatic mode reserves scaled wait count between segments for calibration.
// R12: calibration interval is the longer of wait count and actual calibration.
// R13: mode bit 1 selects manual ramping, 0 selects automatic ramping.
// R14: recalibrate bit forces a calibration request when a segment completes.
// R15: wait count is shifted left by a 3-bit exponent, resetting to 7.
// R16: lock status readback is a 2-bit read-only code.
// R17: selected core readback is a 3-bit read-only field.
// R18: capacitor band readback is 8 bits, 183 after reset.
// R19: amplitude readback is 9 bits, 170 after reset.
// R20: ramp logic runs only while global enable bit is set.
// R21: trigger A and B decode pin edges or always from 4-bit codes.
// R22: on advance, switch segment, reload length, apply new step next cycle.
// R23: configuration resets to zero except scale exponent seven.
`timescale 1ns/1ps
`include "frg_regs.svh"

module frg_ramp (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [8:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Trigger pins
    input  wire logic        sweep_clock_pin,
    input  wire logic        sweep_direction_pin,
    // Calibration engine
    input  wire logic        cal_busy,
    input  wire logic [1:0]  tuning_lock_status,
    input  wire logic [2:0]  selected_core_status,
    input  wire logic [7:0]  capacitor_band_code,
    input  wire logic [8:0]  amplitude_code,
    output logic             cal_request,
    // Ramp output
    output logic [31:0]      sweep_offset,
    output logic             second_segment_active,
    output logic             calibrating
);
    import frg_pkg::*;

    frg_st_t s_reg;
    frg_st_t s_next;

    // Map a register index to a config slot
    function automatic logic [4:0] slot_of(input logic [6:0] idx);
        unique case (idx)
            `FRG_IDX_ENABLE:    slot_of = {1'b1, `FRG_SLOT_ENABLE};
            `FRG_IDX_TRIGGER:   slot_of = {1'b1, `FRG_SLOT_TRIGGER};
            `FRG_IDX_A_STEP_HI: slot_of = {1'b1, `FRG_SLOT_A_STEP_HI};
            `FRG_IDX_A_STEP_LO: slot_of = {1'b1, `FRG_SLOT_A_STEP_LO};
            `FRG_IDX_A_LENGTH:  slot_of = {1'b1, `FRG_SLOT_A_LENGTH};
            `FRG_IDX_A_SEQ:     slot_of = {1'b1, `FRG_SLOT_A_SEQ};
            `FRG_IDX_B_STEP_HI: slot_of = {1'b1, `FRG_SLOT_B_STEP_HI};
            `FRG_IDX_B_STEP_LO: slot_of = {1'b1, `FRG_SLOT_B_STEP_LO};
            `FRG_IDX_B_LENGTH:  slot_of = {1'b1, `FRG_SLOT_B_LENGTH};
            `FRG_IDX_B_SEQ:     slot_of = {1'b1, `FRG_SLOT_B_SEQ};
            `FRG_IDX_CAL_SCALE: slot_of = {1'b1, `FRG_SLOT_CAL_SCALE};
            default:            slot_of = 5'h00;
        endcase
    endfunction : slot_of

    // Writable bits of each slot; reserved bits stay zero
    function automatic logic [15:0] mask_of(input logic [3:0] slot);
        unique case (slot)
            `FRG_SLOT_ENABLE:    mask_of = `FRG_MASK_ENABLE;
            `FRG_SLOT_TRIGGER:   mask_of = `FRG_MASK_TRIGGER;
            `FRG_SLOT_A_STEP_HI: mask_of = `FRG_MASK_A_STEP_HI;
            `FRG_SLOT_A_SEQ:     mask_of = `FRG_MASK_A_SEQ;
            `FRG_SLOT_B_STEP_HI: mask_of = `FRG_MASK_B_STEP_HI;
            `FRG_SLOT_B_SEQ:     mask_of = `FRG_MASK_B_SEQ;
            `FRG_SLOT_CAL_SCALE: mask_of = `FRG_MASK_CAL_SCALE;
            default:             mask_of = `FRG_MASK_FULL;
        endcase
    endfunction : mask_of

    // Decode a trigger source code against the pin edges
    function automatic logic trig_hit(input logic [3:0] code, input logic clk_rise,
                                      input logic clk_fall, input logic dir_rise,
                                      input logic dir_fall);
        unique case (code)
            `FRG_TRG_CLK_RISE: trig_hit = clk_rise; // R21
            `FRG_TRG_DIR_RISE: trig_hit = dir_rise;
            `FRG_TRG_ALWAYS:   trig_hit = 1'b1;
            `FRG_TRG_CLK_FALL: trig_hit = clk_fall;
            `FRG_TRG_DIR_FALL: trig_hit = dir_fall;
            default:           trig_hit = 1'b0;
        endcase
    endfunction : trig_hit

    // Select the event that ends a segment; code 3 never fires
    function automatic logic adv_hit(input logic [1:0] code, input logic expire,
                                     input logic trg_a, input logic trg_b);
        unique case (code)
            `FRG_ADV_LENGTH: adv_hit = expire;
            `FRG_ADV_TRIG_A: adv_hit = trg_a;
            `FRG_ADV_TRIG_B: adv_hit = trg_b;
            default:         adv_hit = 1'b0;
        endcase
    endfunction : adv_hit

    // Start a segment: reload its length and restart the half-rate phase
    function automatic frg_st_t enter_seg(input frg_st_t s, input logic to_b,
                                          input logic clear_acc);
        frg_st_t r;
        r = s;
        r.state   = to_b ? FRG_SEG_B : FRG_SEG_A;
        r.len_cnt = to_b ? s.cfg[`FRG_SLOT_B_LENGTH] : s.cfg[`FRG_SLOT_A_LENGTH]; // R22
        r.half    = 1'b0;
        if (clear_acc) begin
            r.accum = 32'h0000_0000; // R6
        end
        return r;
    endfunction : enter_seg

    logic [6:0]  idx;
    logic [4:0]  slot;
    logic        mapped;
    logic        miss;
    logic        pd_tick;
    logic        sm_tick;
    logic        enabled;
    logic        manual;
    logic        recal;
    logic        trg_a;
    logic        trg_b;
    logic        clk_rise;
    logic        clk_fall;
    logic        dir_rise;
    logic        dir_fall;
    logic        in_b;
    logic        dbl;
    logic        step_tick;
    logic        expire;
    logic        advance;
    logic        go_b;
    logic [29:0] step;
    logic [15:0] a_seq;
    logic [15:0] b_seq;
    logic [15:0] cal_w;
    logic [15:0] trig_w;
    logic [31:0] rd;

    // Decodes and derived fields
    always_comb begin
        idx     = paddr[8:2];
        slot    = slot_of(idx);
        mapped  = slot[4] || idx == `FRG_IDX_LOCK_CORE || idx == `FRG_IDX_CAP_BAND
                  || idx == `FRG_IDX_AMP_CODE;
        miss    = !mapped || paddr[1:0] != 2'h0;
        a_seq   = s_reg.cfg[`FRG_SLOT_A_SEQ];
        b_seq   = s_reg.cfg[`FRG_SLOT_B_SEQ];
        cal_w   = s_reg.cfg[`FRG_SLOT_CAL_SCALE];
        trig_w  = s_reg.cfg[`FRG_SLOT_TRIGGER];
        enabled = s_reg.cfg[`FRG_SLOT_ENABLE][`FRG_BIT_ENABLE];
        manual  = b_seq[`FRG_BIT_MANUAL]; // R13
        recal   = cal_w[`FRG_BIT_RECAL];
        pd_tick = s_reg.pd_cnt == `FRG_PD_DIV - 4'h1;
        sm_tick = s_reg.sm_cnt == `FRG_SM_DIV - 4'h1;
        // Pin edges against the previous cycle's sample; both triggers share them
        clk_rise = sweep_clock_pin && !s_reg.clk_q;
        clk_fall = !sweep_clock_pin && s_reg.clk_q;
        dir_rise = sweep_direction_pin && !s_reg.dir_q;
        dir_fall = !sweep_direction_pin && s_reg.dir_q;
        trg_a   = trig_hit(trig_w[6:3], clk_rise, clk_fall, dir_rise, dir_fall); // R21
        trg_b   = trig_hit(trig_w[10:7], clk_rise, clk_fall, dir_rise, dir_fall); // R21
        in_b    = s_reg.state == FRG_SEG_B;
        dbl     = in_b ? a_seq[`FRG_BIT_B_DOUBLE]
                       : s_reg.cfg[`FRG_SLOT_A_STEP_HI][`FRG_BIT_A_DOUBLE]; // R3
        step_tick = pd_tick && (!dbl || s_reg.half); // R3
        expire  = step_tick && s_reg.len_cnt <= 16'h0001; // R4 R5
        advance = in_b ? adv_hit(b_seq[1:0], expire, trg_a, trg_b)   // R10
                       : adv_hit(a_seq[1:0], expire, trg_a, trg_b);  // R8
        go_b    = in_b ? b_seq[`FRG_BIT_NEXT] : a_seq[`FRG_BIT_NEXT]; // R7 R9
        step    = in_b ? {s_reg.cfg[`FRG_SLOT_B_STEP_HI][13:0], s_reg.cfg[`FRG_SLOT_B_STEP_LO]}
                       : {s_reg.cfg[`FRG_SLOT_A_STEP_HI][15:2], s_reg.cfg[`FRG_SLOT_A_STEP_LO]};
    end

    // Read data mux
    always_comb begin
        rd = 32'h0000_0000;
        if (slot[4]) begin
            rd[15:0] = s_reg.cfg[slot[3:0]];
        end else if (idx == `FRG_IDX_LOCK_CORE) begin
            rd[`FRG_BIT_LOCK +: 2] = s_reg.lock; // R16
            rd[`FRG_BIT_CORE +: 3] = s_reg.core; // R17
        end else if (idx == `FRG_IDX_CAP_BAND) begin
            rd[7:0] = s_reg.cap; // R18
        end else if (idx == `FRG_IDX_AMP_CODE) begin
            rd[8:0] = s_reg.amp; // R19
        end
    end

    // Next-state logic for bus, readback capture and ramp sequencer
    always_comb begin
        s_next = s_reg;
        s_next.cal_req = 1'b0;
        s_next.clk_q   = sweep_clock_pin;
        s_next.dir_q   = sweep_direction_pin;
        s_next.lock    = tuning_lock_status;
        s_next.core    = selected_core_status;
        s_next.cap     = capacitor_band_code;
        s_next.amp     = amplitude_code;
        s_next.pd_cnt  = pd_tick ? 4'h0 : s_reg.pd_cnt + 4'h1;
        s_next.sm_cnt  = sm_tick ? 4'h0 : s_reg.sm_cnt + 4'h1;

        // APB: one wait cycle, then the access completes with pready
        if (psel && penable && !s_reg.ack) begin
            s_next.ack   = 1'b1;
            s_next.rdata = miss ? 32'h0000_0000 : rd;
            s_next.err   = miss;
        end else if (s_reg.ack) begin
            s_next.ack = 1'b0;
            s_next.err = 1'b0;
            if (psel && penable && pwrite && !miss && slot[4]) begin
                s_next.cfg[slot[3:0]] = pwdata[15:0] & mask_of(slot[3:0]);
            end
        end

        // Ramp sequencer
        if (!enabled) begin
            s_next.state = FRG_IDLE; // R20
        end else begin
            unique case (s_reg.state)
                FRG_IDLE: begin
                    s_next = enter_seg(s_next, 1'b0, 1'b0);
                end
                FRG_SEG_A, FRG_SEG_B: begin
                    if (step_tick) begin
                        s_next.accum   = s_reg.accum + {{2{step[29]}}, step}; // R1 R2
                        s_next.len_cnt = s_reg.len_cnt - 16'h0001;
                    end
                    if (pd_tick) begin
                        s_next.half = !s_reg.half;
                    end
                    if (advance) begin
                        s_next.cal_req = !manual || recal; // R14
                        if (!manual) begin
                            s_next.state   = FRG_CAL; // R11
                            s_next.next_b  = go_b;
                            s_next.cal_cnt = 17'({7'h00, b_seq[15:6]} << cal_w[2:0]); // R15
                        end else begin
                            s_next = enter_seg(s_next, go_b, 1'b0); // R22
                        end
                    end
                end
                FRG_CAL: begin
                    if (sm_tick && s_reg.cal_cnt != 17'h00000) begin
                        s_next.cal_cnt = s_reg.cal_cnt - 17'h00001;
                    end
                    if (s_reg.cal_cnt == 17'h00000 && !cal_busy && !s_reg.cal_req) begin
                        s_next = enter_seg(s_next, s_reg.next_b,
                                           s_reg.next_b && a_seq[`FRG_BIT_B_CLEAR]); // R12 R6
                    end
                end
            endcase
        end

        // Status decodes of the next state, so the outputs come from flip-flops
        s_next.seg_b  = s_next.state == FRG_SEG_B;
        s_next.cal_on = s_next.state == FRG_CAL;
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg       <= '0; // R23
            s_reg.cfg[`FRG_SLOT_CAL_SCALE] <= `FRG_RST_CAL_SCALE; // R15
            s_reg.cap   <= `FRG_RST_CAP_BAND;
            s_reg.amp   <= `FRG_RST_AMP_CODE;
            s_reg.state <= FRG_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state register
    assign prdata                = s_reg.rdata;
    assign pready                = s_reg.ack;
    assign pslverr               = s_reg.err;
    assign cal_request           = s_reg.cal_req;
    assign sweep_offset          = s_reg.accum;
    assign second_segment_active = s_reg.seg_b;
    assign calibrating           = s_reg.cal_on;

endmodule : frg_ramp

// *** bench/frg_ramp_properties.sv ***
`timescale 1ns/1ps
`include "frg_regs.svh"
module frg_ramp_checker (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // Register bus
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [8:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Ramp side
    input wire logic        cal_busy,
    input wire logic        cal_request,
    input wire logic [31:0] sweep_offset,
    input wire logic        second_segment_active,
    input wire logic        calibrating
);
    logic       en_reg;
    logic       man_reg;
    logic       wr_ok;
    logic [6:0] idx;
    // Completed write decode
    assign idx   = paddr[8:2];
    assign wr_ok = psel && penable && pready && pwrite && !pslverr;
    // Shadow of the enable and manual bits as software wrote them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_reg  <= 1'b0;
            man_reg <= 1'b0;
        end else if (wr_ok) begin
            if (idx == `FRG_IDX_ENABLE) begin
                en_reg <= pwdata[`FRG_BIT_ENABLE];
            end
            if (idx == `FRG_IDX_B_SEQ) begin
                man_reg <= pwdata[`FRG_BIT_MANUAL];
            end
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_held_off;
        !en_reg ##1 !en_reg |-> $stable(sweep_offset);
    endproperty
    a_held_off: assert property (p_held_off) else $error("offset moved while off");
    property p_manual_nocal;
        man_reg && !calibrating |=> !calibrating;
    endproperty
    a_manual_nocal: assert property (p_manual_nocal) else $error("wait in manual");
    property p_cal_entry;
        $rose(calibrating) |-> cal_request;
    endproperty
    a_cal_entry: assert property (p_cal_entry) else $error("wait without request");
    property p_cal_hold;
        calibrating && cal_busy && en_reg |=> calibrating;
    endproperty
    a_cal_hold: assert property (p_cal_hold) else $error("wait ended while busy");
    property p_req_pulse;
        cal_request |=> !cal_request;
    endproperty
    a_req_pulse: assert property (p_req_pulse) else $error("request too long");
    property p_step_space;
        !$stable(sweep_offset) && !second_segment_active |=> $stable(sweep_offset)[*3];
    endproperty
    a_step_space: assert property (p_step_space) else $error("steps too close");
    property p_band_upper;
        pready && !pwrite && !pslverr && idx == `FRG_IDX_CAP_BAND |-> prdata[31:8] == 24'h0;
    endproperty
    a_band_upper: assert property (p_band_upper) else $error("band upper bits set");
    property p_lock_layout;
        pready && !pwrite && !pslverr && idx == `FRG_IDX_LOCK_CORE
            |-> prdata[31:11] == 21'h0 && !prdata[8] && prdata[4:0] == 5'h0;
    endproperty
    a_lock_layout: assert property (p_lock_layout) else $error("status spare bits set");
    c_seg_b: cover property ($rose(second_segment_active));
    c_cal: cover property ($rose(calibrating));
    c_err: cover property (pready && pslverr);
endmodule : frg_ramp_checker

bind frg_ramp frg_ramp_checker u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cal_busy(cal_busy), .cal_request(cal_request), .sweep_offset(sweep_offset),
    .second_segment_active(second_segment_active), .calibrating(calibrating));

// *** bench/frequency_ramp_generator_tb.sv ***
`timescale 1ns/1ps
`include "frg_regs.svh"
module frequency_ramp_generator_tb;
    import frg_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [8:0]  paddr = 9'h000;
    logic [31:0] pwdata = 32'h0;
    logic        sweep_clock_pin = 1'b0;
    logic        sweep_direction_pin = 1'b0;
    logic        cal_busy = 1'b0;
    logic [1:0]  lock_in = 2'h0;
    logic [2:0]  core_in = 3'h0;
    logic [7:0]  cap_in = 8'h00;
    logic [8:0]  amp_in = 9'h000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        cal_request;
    logic [31:0] sweep_offset;
    logic        second_segment_active;
    logic        calibrating;
    logic [31:0] rd;
    logic        er;
    int          err_total = 0;
    int          check_count = 0;
    logic [15:0] msk [9] = '{`FRG_MASK_A_STEP_HI, `FRG_MASK_FULL, `FRG_MASK_FULL,
        `FRG_MASK_A_SEQ, `FRG_MASK_B_STEP_HI, `FRG_MASK_FULL, `FRG_MASK_FULL,
        `FRG_MASK_B_SEQ, `FRG_MASK_CAL_SCALE};

    frg_ramp dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sweep_clock_pin(sweep_clock_pin),
        .sweep_direction_pin(sweep_direction_pin), .cal_busy(cal_busy),
        .tuning_lock_status(lock_in), .selected_core_status(core_in),
        .capacitor_band_code(cap_in), .amplitude_code(amp_in),
        .cal_request(cal_request), .sweep_offset(sweep_offset),
        .second_segment_active(second_segment_active), .calibrating(calibrating));

    // Clock and wandering trigger pins
    always #5 pclk = ~pclk;
    always @(posedge pclk) begin
        sweep_clock_pin     <= 1'($urandom);
        sweep_direction_pin <= 1'($urandom);
    end

    task automatic end_sim;
        $display("Checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // One APB transfer; values are sampled before the edge's updates land
    task automatic apb(input logic wr, input logic [6:0] idx, input logic [15:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= {16'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        chk("pready", 32'h1, {31'h0, pready});
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic logic [31:0] sx(input logic [29:0] s);
        return {{2{s[29]}}, s};
    endfunction : sx

    // Watchdog
    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        end_sim();
    end

    initial begin
        logic [29:0] sa;
        logic [29:0] sb;
        logic [31:0] cur;
        logic [31:0] exp;
        logic [15:0] d;
        logic        sg;
        logic        es;
        int          n;
        void'($urandom(47));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        lock_in <= 2'($urandom);
        core_in <= 3'($urandom);
        cap_in  <= 8'($urandom);
        amp_in  <= 9'($urandom);
        apb(0, `FRG_IDX_CAL_SCALE, 16'h0);
        chk("cal_scale_reset", {16'h0, `FRG_RST_CAL_SCALE}, rd);
        apb(0, `FRG_IDX_A_SEQ, 16'h0);
        chk("a_seq_reset", 32'h0, rd);
        apb(0, `FRG_IDX_LOCK_CORE, 16'h0);
        chk("lock_core", {21'h0, lock_in, 1'b0, core_in, 5'h0}, rd);
        apb(1, `FRG_IDX_CAP_BAND, 16'hffff);
        apb(0, `FRG_IDX_CAP_BAND, 16'h0);
        chk("cap_band", {24'h0, cap_in}, rd);
        apb(0, `FRG_IDX_AMP_CODE, 16'h0);
        chk("amp_code", {23'h0, amp_in}, rd);
        apb(1, 7'h14, 16'h1234);
        chk("unmapped_err", 32'h1, {31'h0, er});
        // Writable fields keep only their defined bits
        for (int i = 0; i < 9; i++) begin
            d = 16'($urandom);
            apb(1, 7'(`FRG_IDX_A_STEP_HI + i), d);
            apb(0, 7'(`FRG_IDX_A_STEP_HI + i), 16'h0);
            chk("cfg_rw", {16'h0, d & msk[i]}, rd);
        end
        // Manual ramp: two steps of A, three of B, repeating
        sa = 30'($urandom);
        sb = 30'($urandom);
        apb(1, `FRG_IDX_A_STEP_HI, {sa[29:16], 2'b00});
        apb(1, `FRG_IDX_A_STEP_LO, sa[15:0]);
        apb(1, `FRG_IDX_A_LENGTH, 16'h0002);
        apb(1, `FRG_IDX_A_SEQ, 16'h0010);
        apb(1, `FRG_IDX_B_STEP_HI, {2'b00, sb[29:16]});
        apb(1, `FRG_IDX_B_STEP_LO, sb[15:0]);
        apb(1, `FRG_IDX_B_LENGTH, 16'h0003);
        apb(1, `FRG_IDX_B_SEQ, 16'h0020);
        apb(1, `FRG_IDX_CAL_SCALE, 16'h0000);
        apb(1, `FRG_IDX_ENABLE, 16'h8000);
        exp = 32'h0;
        for (int k = 0; k < 15; k++) begin
            cur = sweep_offset;
            sg  = second_segment_active;
            n   = 0;
            while (sweep_offset === cur && n < 40) begin
                sg = second_segment_active;
                @(posedge pclk);
                n++;
            end
            es  = ((k % 5) >= 2);
            exp = exp + (es ? sx(sb) : sx(sa));
            chk("segment", {31'h0, es}, {31'h0, sg});
            chk("offset", exp, sweep_offset);
        end
        apb(1, `FRG_IDX_ENABLE, 16'h0000);
        repeat (2) @(posedge pclk);
        cur = sweep_offset;
        repeat (20) @(posedge pclk);
        chk("held_off", cur, sweep_offset);
        // Automatic ramp with calibration wait and clear on entering B
        apb(1, `FRG_IDX_A_SEQ, 16'h0030);
        apb(1, `FRG_IDX_B_SEQ, 16'h00c0);
        cal_busy <= 1'b1;
        apb(1, `FRG_IDX_ENABLE, 16'h8000);
        n = 0;
        while (calibrating !== 1'b1 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        chk("req_at_wait", 32'h1, {31'h0, cal_request});
        repeat (100) @(posedge pclk);
        chk("wait_busy", 32'h1, {31'h0, calibrating});
        cal_busy <= 1'b0;
        n = 0;
        while (second_segment_active !== 1'b1 && n < 60) begin
            @(posedge pclk);
            n++;
        end
        chk("wait_over", 32'h1, {31'h0, second_segment_active});
        chk("cleared", 32'h0, sweep_offset);
        // Manual ramp, double-length A; B left at once by an always-firing trigger A
        apb(1, `FRG_IDX_ENABLE, 16'h0000);
        apb(1, `FRG_IDX_TRIGGER, {5'h00, `FRG_TRG_OFF, `FRG_TRG_ALWAYS, 3'h0});
        apb(1, `FRG_IDX_A_STEP_HI, {sa[29:16], 2'b01});
        apb(1, `FRG_IDX_A_LENGTH, 16'h0001);
        apb(1, `FRG_IDX_A_SEQ, 16'h0010);
        apb(1, `FRG_IDX_B_SEQ, 16'h0021);
        exp = sweep_offset;
        apb(1, `FRG_IDX_ENABLE, 16'h8000);
        for (int k = 0; k < 4; k++) begin
            cur = sweep_offset;
            n   = 0;
            while (sweep_offset === cur && n < 40) begin
                @(posedge pclk);
                n++;
            end
            exp = exp + sx(sa);
            chk("double_offset", exp, sweep_offset);
            if (k > 0) begin
                chk("double_space", 32'd8, 32'(n));
            end
        end
        end_sim();
    end
endmodule : frequency_ramp_generator_tb
